//--- inc/bcc_defs.svh
// register indices, field positions, reset values and counts for the calendar clock core
// Summary of operation
// - two pages, shared status register selects page
// - page 0 clock, page 1 scratch; two blocks
// - oscillator idle until crystal select written
// - ten synchronous BCD counters, hundredths to years
// - calendar counters wrap to one except year, others zero
// - 12-hour hours wrap to one, toggle PM
// - day of year twelve bits, two addresses
// - counters undefined until host writes time
// - periodic event at rollover; host services quickly
// - time save enable copies; clearing it freezes
// - snapshot touches only used bits
// - snapshot never catches partial rollover
// - run bit clear halts counting and carries
// - stopping clock clears prescaler fraction
// - prescaler divides crystal to 32 kHz, 100 Hz
// - crystal select picks one of four rates
// - timer and clock prescalers enabled separately
// - reading periodic flags clears only the bits read
// - periodic flag sets at counter rollover
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH
`define BCC_IDX_MSR 5'h00
`define BCC_IDX_RTM 5'h01
`define BCC_IDX_TCTL 5'h02
`define BCC_IDX_PFLAG 5'h03
`define BCC_IDX_ROUTE 5'h04
`define BCC_IDX_CNT0 5'h05
`define BCC_IDX_CNTN 5'h0E
`define BCC_IDX_TS0 5'h0F
`define BCC_NUM_CNT 10
`define BCC_NUM_TS 5
`define BCC_C_HUN 0
`define BCC_C_SEC 1
`define BCC_C_MIN 2
`define BCC_C_HR 3
`define BCC_C_DOM 4
`define BCC_C_MON 5
`define BCC_C_YR 6
`define BCC_C_DOYL 7
`define BCC_C_DOYH 8
`define BCC_C_DOW 9
`define BCC_MSR_PAGE 6
`define BCC_MSR_BLOCK 7
`define BCC_RTM_12H 2
`define BCC_RTM_RUN 3
`define BCC_RTM_XSEL 5:4
`define BCC_ROUTE_TSE 7
`define BCC_TCTL_RUN 0
`define BCC_RTM_RST 8'h00
`define BCC_ROUTE_RST 8'h00
`define BCC_MASK_SEC 8'h7F
`define BCC_MASK_MIN 8'h7F
`define BCC_MASK_HR 8'hBF
`define BCC_MASK_DOM 8'h3F
`define BCC_MASK_MON 8'h1F
`define BCC_TICK_HZ 100
`define BCC_FINT_32K 16'h7D00
`define BCC_FINT_32768 16'h8000
`define BCC_DIV_4194 8'h80
`define BCC_DIV_4915 8'h96
`endif

//--- inc/bcc_pkg.sv
// types shared by the calendar clock core
`default_nettype none
package bcc_pkg;
   typedef logic [7:0] bcc_byte_t;
   typedef enum logic [1:0] {
      BCC_X32K = 2'h0,
      BCC_X32768 = 2'h1,
      BCC_X4194 = 2'h2,
      BCC_X4915 = 2'h3
   } bcc_xtal_e;
   typedef enum logic [2:0] {
      BCC_LOC_MSR = 3'h0,
      BCC_LOC_RTM = 3'h1,
      BCC_LOC_TCTL = 3'h2,
      BCC_LOC_PFLAG = 3'h3,
      BCC_LOC_ROUTE = 3'h4,
      BCC_LOC_CNT = 3'h5,
      BCC_LOC_RAM = 3'h6
   } bcc_loc_e;
endpackage
`default_nettype wire

//--- hdl/bcc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module bcc_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_bad_w
      $error("bcc_sync2: W must be at least 1");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

//--- hdl/bcc_prescaler.sv
// crystal prescaler: crystal edges to 32 kHz, then to the counter tick
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defs.svh"
module bcc_prescaler #(
   parameter int TICK_HZ = `BCC_TICK_HZ
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_in,
   input wire logic osc_en,
   input wire logic [1:0] xtal_sel,
   input wire logic clk_run,
   input wire logic tmr_run,
   output logic tick_clk,
   output logic tick_tmr
);
   logic osc_s;
   logic osc_d;
   logic rise;
   logic p32;
   logic [7:0] cnt1;
   logic [7:0] div;
   logic [15:0] fint;
   logic [15:0] acc;
   logic [16:0] sum;
   logic wrap;

   if (TICK_HZ < 1 || TICK_HZ > 32000) begin : g_bad_hz
      $error("bcc_prescaler: TICK_HZ out of range");
   end

   bcc_sync2 #(.W(1)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(osc_in),
      .q(osc_s)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_d <= 1'b0;
      end else begin
         osc_d <= osc_s;
      end
   end

   // oscillator stays idle until the crystal select has been written
   assign rise = osc_s & ~osc_d & osc_en;

   always_comb begin
      case (bcc_pkg::bcc_xtal_e'(xtal_sel))
         bcc_pkg::BCC_X4194: div = `BCC_DIV_4194;
         bcc_pkg::BCC_X4915: div = `BCC_DIV_4915;
         default: div = 8'h01;
      endcase
      fint = (xtal_sel == 2'h0) ? `BCC_FINT_32K : `BCC_FINT_32768;
   end

   // >= tolerates a select change while the count is above the new divide
   assign p32 = rise & (cnt1 >= div - 8'h01);
   assign sum = {1'b0, acc} + 17'(TICK_HZ);
   assign wrap = sum >= {1'b0, fint};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt1 <= 8'h00;
      end else if (!osc_en) begin
         cnt1 <= 8'h00;
      end else if (rise) begin
         cnt1 <= p32 ? 8'h00 : cnt1 + 8'h01;
      end
   end

   // fractional divide keeps 32.768 kHz exact; clearing drops the fraction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc <= 16'h0000;
      end else if (!clk_run || !osc_en) begin
         acc <= 16'h0000;
      end else if (p32) begin
         acc <= wrap ? 16'(sum - {1'b0, fint}) : sum[15:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_clk <= 1'b0;
         tick_tmr <= 1'b0;
      end else begin
         tick_clk <= clk_run & osc_en & p32 & wrap;
         tick_tmr <= tmr_run & p32;
      end
   end
endmodule
`default_nettype wire

//--- hdl/bcc_core.sv
// calendar clock core: APB register map, BCD counter chain, time save
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defs.svh"
module bcc_core #(
   parameter int PADDR_W = 8,
   parameter int TICK_HZ = `BCC_TICK_HZ
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_in,
   output logic tick_tmr
);
   logic [7:0] cnt [0:`BCC_NUM_CNT-1];
   logic [7:0] next_cnt [0:`BCC_NUM_CNT-1];
   logic [7:0] ram [0:63];
   logic [7:0] rtm;
   logic [7:0] route;
   logic [5:0] pflag;
   logic page;
   logic block;
   logic xtal_set;
   logic tmr_run;
   logic [4:0] idx;
   logic [5:0] ram_idx;
   logic [3:0] cidx;
   logic bad;
   logic setup;
   logic wr;
   logic rd_done;
   bcc_pkg::bcc_loc_e loc;
   logic [7:0] rd_byte;
   logic tick;
   logic c_sec;
   logic c_min;
   logic c_hr;
   logic c_day;
   logic c_mon;
   logic c_yr;
   logic [5:0] ev;
   logic m12;

   if (PADDR_W < 7) begin : g_bad_aw
      $error("bcc_core: PADDR_W must be at least 7");
   end

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
      return (v == last) ? first : bcd_inc(v);
   endfunction

   // two BCD year digits: divisible by four
   function automatic logic leap(input logic [7:0] y);
      logic ones0;
      logic ones2;
      ones0 = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      ones2 = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      return y[4] ? ones2 : ones0;
   endfunction

   function automatic logic [7:0] dim(input logic [7:0] m, input logic lp);
      logic [7:0] d;
      case (m)
         8'h02: d = lp ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
         default: d = 8'h31;
      endcase
      return d;
   endfunction

   function automatic logic [7:0] hr_step(input logic [7:0] h, input logic mode12);
      logic [7:0] n;
      n = bcd_inc({2'b00, h[5:0]});
      if (!mode12) begin
         return step(h, 8'h23, 8'h00);
      end else if (h[5:0] == 6'h12) begin
         return {h[7], 7'h01};
      end else begin
         return {h[7] ^ (n == 8'h12), n[6:0]};
      end
   endfunction

   function automatic logic [7:0] ts_mask(input int k);
      logic [7:0] m;
      case (k)
         0: m = `BCC_MASK_SEC;
         1: m = `BCC_MASK_MIN;
         2: m = `BCC_MASK_HR;
         3: m = `BCC_MASK_DOM;
         default: m = `BCC_MASK_MON;
      endcase
      return m;
   endfunction

   function automatic bcc_pkg::bcc_loc_e decode(input logic [4:0] i, input logic pg, input logic blk);
      bcc_pkg::bcc_loc_e l;
      l = bcc_pkg::BCC_LOC_RAM;
      if (i == `BCC_IDX_MSR) begin
         l = bcc_pkg::BCC_LOC_MSR;
      end else if (pg) begin
         l = bcc_pkg::BCC_LOC_RAM;
      end else if (i >= `BCC_IDX_CNT0 && i <= `BCC_IDX_CNTN) begin
         l = bcc_pkg::BCC_LOC_CNT;
      end else if (i == `BCC_IDX_RTM && blk) begin
         l = bcc_pkg::BCC_LOC_RTM;
      end else if (i == `BCC_IDX_TCTL && blk) begin
         l = bcc_pkg::BCC_LOC_TCTL;
      end else if (i == `BCC_IDX_PFLAG && !blk) begin
         l = bcc_pkg::BCC_LOC_PFLAG;
      end else if (i == `BCC_IDX_ROUTE && !blk) begin
         l = bcc_pkg::BCC_LOC_ROUTE;
      end
      return l;
   endfunction

   assign idx = paddr[6:2];
   assign bad = (paddr >> 7) != '0;
   assign ram_idx = {page, idx};
   assign cidx = 4'(idx - `BCC_IDX_CNT0);
   assign loc = decode(idx, page, block);
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & ~bad;
   assign rd_done = psel & penable & ~pwrite & ~bad;
   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & bad;
   assign m12 = rtm[`BCC_RTM_12H];

   bcc_prescaler #(.TICK_HZ(TICK_HZ)) u_pre (
      .clk(clk),
      .rst(rst),
      .osc_in(osc_in),
      .osc_en(xtal_set),
      .xtal_sel(rtm[`BCC_RTM_XSEL]),
      .clk_run(rtm[`BCC_RTM_RUN]),
      .tmr_run(tmr_run),
      .tick_clk(tick),
      .tick_tmr(tick_tmr)
   );

   // control registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page <= 1'b0;
         block <= 1'b0;
      end else if (wr && loc == bcc_pkg::BCC_LOC_MSR) begin
         page <= pwdata[`BCC_MSR_PAGE];
         block <= pwdata[`BCC_MSR_BLOCK];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rtm <= `BCC_RTM_RST;
         xtal_set <= 1'b0;
      end else if (wr && loc == bcc_pkg::BCC_LOC_RTM) begin
         rtm <= pwdata[7:0];
         xtal_set <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmr_run <= 1'b0;
      end else if (wr && loc == bcc_pkg::BCC_LOC_TCTL) begin
         tmr_run <= pwdata[`BCC_TCTL_RUN];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route <= `BCC_ROUTE_RST;
      end else if (wr && loc == bcc_pkg::BCC_LOC_ROUTE) begin
         route <= pwdata[7:0];
      end
   end

   // periodic flags: a read clears only the bits the host saw, a write clears all; a new set wins
   assign ev = {c_day, c_hr, c_min, c_sec, tick & (cnt[`BCC_C_HUN][3:0] == 4'h9), tick};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pflag <= 6'h00;
      end else if (rd_done && loc == bcc_pkg::BCC_LOC_PFLAG) begin
         pflag <= (pflag & ~prdata[5:0]) | ev;
      end else if (wr && loc == bcc_pkg::BCC_LOC_PFLAG) begin
         pflag <= ev;
      end else begin
         pflag <= pflag | ev;
      end
   end

   // counter chain; a stopped prescaler gives no tick and so no carries
   always_comb begin
      next_cnt = cnt;
      c_sec = tick & (cnt[`BCC_C_HUN] == 8'h99);
      c_min = c_sec & (cnt[`BCC_C_SEC] == 8'h59);
      c_hr = c_min & (cnt[`BCC_C_MIN] == 8'h59);
      c_day = c_hr & (m12 ? (cnt[`BCC_C_HR] == 8'h91) : (cnt[`BCC_C_HR] == 8'h23));
      c_mon = c_day & (cnt[`BCC_C_DOM] == dim(cnt[`BCC_C_MON], leap(cnt[`BCC_C_YR])));
      c_yr = c_mon & (cnt[`BCC_C_MON] == 8'h12);
      if (tick) begin
         next_cnt[`BCC_C_HUN] = step(cnt[`BCC_C_HUN], 8'h99, 8'h00);
      end
      if (c_sec) begin
         next_cnt[`BCC_C_SEC] = step(cnt[`BCC_C_SEC], 8'h59, 8'h00);
      end
      if (c_min) begin
         next_cnt[`BCC_C_MIN] = step(cnt[`BCC_C_MIN], 8'h59, 8'h00);
      end
      if (c_hr) begin
         next_cnt[`BCC_C_HR] = hr_step(cnt[`BCC_C_HR], m12);
      end
      if (c_day) begin
         next_cnt[`BCC_C_DOM] = step(cnt[`BCC_C_DOM], dim(cnt[`BCC_C_MON], leap(cnt[`BCC_C_YR])), 8'h01);
         next_cnt[`BCC_C_DOW] = step(cnt[`BCC_C_DOW], 8'h07, 8'h01);
         if (c_yr) begin
            next_cnt[`BCC_C_DOYL] = 8'h01;
            next_cnt[`BCC_C_DOYH] = {cnt[`BCC_C_DOYH][7:4], 4'h0};
         end else if (cnt[`BCC_C_DOYL] == 8'h99) begin
            next_cnt[`BCC_C_DOYL] = 8'h00;
            next_cnt[`BCC_C_DOYH] = {cnt[`BCC_C_DOYH][7:4], cnt[`BCC_C_DOYH][3:0] + 4'h1};
         end else begin
            next_cnt[`BCC_C_DOYL] = bcd_inc(cnt[`BCC_C_DOYL]);
         end
      end
      if (c_mon) begin
         next_cnt[`BCC_C_MON] = step(cnt[`BCC_C_MON], 8'h12, 8'h01);
      end
      if (c_yr) begin
         next_cnt[`BCC_C_YR] = step(cnt[`BCC_C_YR], 8'h99, 8'h00);
      end
      // a host load beats the carry into the same byte
      if (wr && loc == bcc_pkg::BCC_LOC_CNT) begin
         next_cnt[cidx] = pwdata[7:0];
      end
   end

   // no reset: counter contents are meaningless until the host writes a time
   always_ff @(posedge clk) begin
      for (int i = 0; i < `BCC_NUM_CNT; i++) begin
         cnt[i] <= next_cnt[i];
      end
   end

   // scratch storage and time save copy
   always_ff @(posedge clk) begin
      if (wr && loc == bcc_pkg::BCC_LOC_RAM) begin
         ram[ram_idx] <= pwdata[7:0];
      end
      // copy from registered counters, which change all in one edge
      if (route[`BCC_ROUTE_TSE]) begin
         for (int k = 0; k < `BCC_NUM_TS; k++) begin
            ram[{1'b0, 5'(`BCC_IDX_TS0 + 5'(k))}] <=
               (ram[{1'b0, 5'(`BCC_IDX_TS0 + 5'(k))}] & ~ts_mask(k)) | (cnt[k + 1] & ts_mask(k));
         end
      end
   end

   always_comb begin
      case (loc)
         bcc_pkg::BCC_LOC_MSR: rd_byte = {block, page, 6'h00};
         bcc_pkg::BCC_LOC_RTM: rd_byte = rtm;
         bcc_pkg::BCC_LOC_TCTL: rd_byte = {7'h00, tmr_run};
         bcc_pkg::BCC_LOC_PFLAG: rd_byte = {2'h0, pflag};
         bcc_pkg::BCC_LOC_ROUTE: rd_byte = route;
         bcc_pkg::BCC_LOC_CNT: rd_byte = cnt[cidx];
         default: rd_byte = ram[ram_idx];
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= bad ? 32'h0000_0000 : {24'h000000, rd_byte};
      end
   end
endmodule
`default_nettype wire

//--- verification/bcc_xtal_model.sv
// crystal source model: bursts of oscillator edges, idle low between bursts
`timescale 1ns/1ns
`default_nettype none
module bcc_xtal_model (
   output logic osc_in
);
   initial osc_in = 1'b0;
   // own time base, unrelated in phase to the bus clock; about 4.8 MHz
   task automatic run(input int n);
      repeat (n) begin
         #105 osc_in = 1'b1;
         #105 osc_in = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

//--- verification/bcc_core_checker.sv
// port checks for the calendar clock core, bound to bcc_core
`timescale 1ns/1ns
`default_nettype none
module bcc_core_checker #(
   parameter int PADDR_W = 8,
   parameter int TICK_HZ = 100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_in,
   input wire logic tick_tmr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic unmapped;
   logic wr_ok;
   logic [7:0] msr_q;
   logic osc_on;
   assign unmapped = |(paddr >> 7);
   assign wr_ok = psel && penable && pwrite && !unmapped;
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         msr_q <= 8'h00;
      else if (wr_ok && paddr[6:2] == 5'h00)
         msr_q <= pwdata[7:0];
   end
   // mode register lives in block 1 of page 0; its first write wakes the oscillator
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         osc_on <= 1'b0;
      else if (wr_ok && paddr[6:2] == 5'h01 && msr_q[7:6] == 2'b10)
         osc_on <= 1'b1;
   end
   ready_now_a: assert property (access_s |-> pready)
      else $error("access phase without ready");
   err_map_a: assert property (access_s |-> pslverr == unmapped)
      else $error("error response does not match address");
   err_idle_a: assert property (!(psel && penable) |-> !pslverr)
      else $error("error response outside access phase");
   rdata_upper_a: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data changed without setup");
   unmapped_zero_a: assert property (setup_s ##0 unmapped |=> prdata == 32'h0)
      else $error("unmapped read returned data");
   status_bits_a: assert property (setup_s ##0 (paddr[6:2] == 5'h00 && !unmapped) |=> prdata[5:0] == 6'h0)
      else $error("status register unused bits set");
   osc_gate_a: assert property (tick_tmr |-> osc_on)
      else $error("timebase pulse before crystal select written");
   tick_pulse_a: assert property (tick_tmr |=> !tick_tmr)
      else $error("timebase pulse longer than one cycle");
endmodule
bind bcc_core bcc_core_checker #(.PADDR_W(PADDR_W), .TICK_HZ(TICK_HZ)) chk_i (
   .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
   .tick_tmr(tick_tmr)
);
`default_nettype wire

//--- verification/bcd_calendar_clock_core_tb.sv
// self-checking bench for the calendar clock core with a behavioural clock model
`timescale 1ns/1ns
`default_nettype none
module bcd_calendar_clock_core_tb;
   localparam int THZ = 16000;
   localparam int HI[3] = '{'h99, 'h59, 'h59};
   localparam int MSK[5] = '{'h7F, 'h7F, 'hBF, 'h3F, 'h1F};
   localparam int H12[4] = '{'h11, 'h92, 'h91, 'h12};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc_in;
   logic tick_tmr;
   logic [31:0] rd;
   logic se;
   logic [7:0] ram[32];
   int failures = 0;
   int num_checks = 0;
   int ntt = 0;
   int n0;
   int mv;
   int acc = 0;
   int pf = 0;
   int c[10];
   int ts[5];
   bcc_core #(.TICK_HZ(THZ)) dut (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
      .tick_tmr(tick_tmr)
   );
   bcc_xtal_model xo (.osc_in(osc_in));
   initial forever #25 clk = ~clk;
   always @(posedge clk)
      if (tick_tmr === 1'b1)
         ntt <= ntt + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic w(input int i, input int d);
      bus(1'b1, 8'(i * 4), 8'(d));
   endtask
   task automatic r(input int i, input int e);
      bus(1'b0, 8'(i * 4), 8'h00);
      chk(rd, 32'(e));
   endtask
   // stopping also clears the fractional count
   task automatic mode(input int v);
      mv = v;
      if (v % 16 < 8)
         acc = 0;
      w(0, 'h80);
      w(1, v);
      w(0, 0);
   endtask
   task automatic ldall();
      for (int i = 0; i < 10; i++)
         w(5 + i, c[i]);
   endtask
   task automatic cmpall();
      for (int i = 0; i < 10; i++)
         r(5 + i, c[i]);
   endtask
   function automatic int inc(input int v);
      return (v % 16 == 9) ? v + 7 : v + 1;
   endfunction
   function automatic int dv(input int s);
      return s < 2 ? 1 : (s == 2 ? 128 : 150);
   endfunction
   task automatic tick();
      int ml;
      pf |= (c[0] % 16 == 9) ? 3 : 1;
      for (int i = 0; i < 3; i++) begin
         c[i] = c[i] == HI[i] ? 0 : inc(c[i]);
         if (c[i] != 0)
            return;
         pf |= 4 << i;
      end
      if (mv / 4 % 2 && c[3] % 128 == 'h12)
         c[3] = c[3] - 'h11;
      else if (mv / 4 % 2 && c[3] % 128 == 'h11)
         c[3] = c[3] ^ 'h83;
      else
         c[3] = c[3] == 'h23 ? 0 : inc(c[3]);
      if (c[3] != (mv / 4 % 2 ? 'h12 : 0))
         return;
      pf |= 32;
      c[9] = c[9] % 7 + 1;
      ml = c[5] == 2 ? ((c[6] / 16 * 10 + c[6] % 16) % 4 ? 'h28 : 'h29) : (c[5] inside {4, 6, 9, 'h11} ? 'h30 : 'h31);
      c[7] = c[7] == 'h99 ? 0 : inc(c[7]);
      c[8] += c[7] == 0;
      c[4] = c[4] == ml ? 1 : inc(c[4]);
      if (c[4] != 1)
         return;
      c[5] = c[5] == 'h12 ? 1 : inc(c[5]);
      if (c[5] != 1)
         return;
      c[6] = c[6] == 'h99 ? 0 : inc(c[6]);
      c[7] = 1;
      c[8] = 0;
   endtask
   // whole multiples of the first divide keep its phase out of the result
   task automatic osc(input int n);
      int s;
      s = mv / 16 % 4;
      xo.run(n);
      repeat (8) @(posedge clk);
      if (mv % 16 >= 8)
         repeat (n / dv(s)) begin
            acc += THZ;
            if (acc >= (s == 0 ? 32000 : 32768)) begin
               acc -= (s == 0 ? 32000 : 32768);
               tick();
            end
         end
   endtask
   initial begin
      #2000000;
      failures++;
      give_verdict();
   end
   initial begin
      rd = $urandom(42813);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      r(0, 0);
      w(0, 'h80);
      r(1, 0);
      r(2, 0);
      w(0, 0);
      r(3, 0);
      r(4, 0);
      $display("reset values done");
      w(0, 'h40);
      for (int i = 1; i < 32; i++) begin
         ram[i] = 8'($urandom);
         w(i, ram[i]);
      end
      for (int i = 1; i < 32; i++)
         r(i, ram[i]);
      w(0, 'h80);
      w(3, ram[5]);
      r(3, ram[5]);
      bus(1'b1, 8'h80, 8'h5A);
      chk(se, 1);
      r(0, 'h80);
      bus(1'b0, 8'hFC, 8'h00);
      chk(rd | se, 1);
      $display("memory map done");
      mode(0);
      c = '{'h99, 'h59, 'h59, 'h23, 'h31, 'h12, 'h99, 'h65, 'h03, 'h07};
      ldall();
      osc(4);
      cmpall();
      bus(1'b0, 8'h0C, 8'h00);
      pf = 0;
      mode(8);
      osc(2);
      r(3, pf);
      r(3, 0);
      cmpall();
      osc(1);
      mode(0);
      mode(8);
      osc(3);
      r(5, c[0]);
      for (int s = 0; s < 4; s++) begin
         mode(s * 16);
         mode(s * 16 + 8);
         osc(4 * dv(s));
         r(5, c[0]);
      end
      $display("count chain done");
      for (int k = 0; k < 4; k++) begin
         mode(4);
         for (int j = 0; j < 3; j++)
            c[j] = HI[j];
         c[3] = H12[k];
         ldall();
         mode('h0C);
         osc(2);
         r(8, c[3]);
         r(9, c[4]);
      end
      mode(0);
      mode(8);
      w(0, 'h80);
      w(2, 1);
      n0 = ntt;
      osc(6);
      chk(ntt - n0, 6);
      w(2, 0);
      n0 = ntt;
      osc(6);
      chk(ntt - n0, 0);
      w(0, 0);
      $display("twelve hour and timebase done");
      for (int j = 0; j < 5; j++)
         w(15 + j, 'hFF);
      w(4, 'h80);
      osc(2);
      w(4, 0);
      for (int j = 0; j < 5; j++)
         ts[j] = c[j + 1] & MSK[j] | 'hFF & ~MSK[j];
      osc(40);
      for (int j = 0; j < 5; j++)
         r(15 + j, ts[j]);
      cmpall();
      $display("time save done");
      bus(1'b0, 8'h0C, 8'h00);
      pf = 0;
      osc(2);
      r(3, pf);
      // settle time after the hundredth event before an on-the-fly load
      repeat (320) @(posedge clk);
      c[2] = 'h42;
      w(7, c[2]);
      osc(2);
      cmpall();
      osc(2);
      w(3, 'hFF);
      r(3, 0);
      $display("running write done");
      give_verdict();
   end
endmodule
`default_nettype wire
